// file: afe_ctrl_map.svh
`ifndef AFE_CTRL_MAP_SVH
`define AFE_CTRL_MAP_SVH
// register addresses within a device (3-bit field of the control word)
`define ADDR_SERIAL_MODE   3'h0
`define ADDR_CLOCK_RATE    3'h1
`define ADDR_POWER_REF     3'h2
`define ADDR_GAIN_CH12     3'h3
`define ADDR_GAIN_CH34     3'h4
`define ADDR_GAIN_CH56     3'h5
`define ADDR_INPUT_MODE    3'h6
`define ADDR_INVERT        3'h7
// all registers reset to zero
`define REG_RESET_VALUE    8'h00
// serial mode register fields
`define SM_OPMODE_BIT      0
`define SM_MIXED_BIT       1
`define SM_LOOPBACK_BIT    3
`define SM_CASCADE_LSB     4
`define SM_SOFT_RESET_BIT  7
// clock rate register fields
`define CR_DECIM_LSB       0
`define CR_SCLK_DIV_LSB    2
`define CR_MCLK_DIV_LSB    4
`define CR_ECHO_BIT        7
// power / reference register fields
`define PR_GLOBAL_BIT      0
`define PR_REF_POWER_BIT   5
`define PR_REF_OUT_BIT     6
// gain / power register fields (odd channel low nibble)
`define GP_LOW_GAIN_LSB    0
`define GP_LOW_POWER_BIT   3
`define GP_HIGH_GAIN_LSB   4
`define GP_HIGH_POWER_BIT  7
// input mode and invert fields
`define SEL_LSB            0
`define IM_MOD_RESET_BIT   6
`define IM_SINGLE_BIT      7
`define IV_TEST_BIT        6
`define IV_ENABLE_BIT      7
`endif

// file: afe_ctrl_pkg.sv
`default_nettype none
package afe_ctrl_pkg;
    typedef enum logic [1:0] {
        mode_program,
        mode_data,
        mode_mixed
    } op_mode_t;

    typedef struct packed {
        logic       valid;
        logic [2:0] addr;
        logic [7:0] data;
    } reg_write_t;

    typedef struct packed {
        op_mode_t   op_mode;
        logic       serial_loopback_enable;
        logic [2:0] cascade_count;
        logic [1:0] decimation_rate;
        logic [1:0] serial_clock_div;
        logic [2:0] master_clock_div;
        logic       control_echo_enable;
    } port_config_t;

    typedef struct packed {
        logic [5:0]  channel_power;
        logic [17:0] channel_gain;
        logic        reference_power_on;
        logic        reference_output_pin;
        logic [5:0]  modulator_reset;
        logic [5:0]  single_ended;
        logic [5:0]  invert;
        logic        test_mode_bit;
    } analog_config_t;
endpackage : afe_ctrl_pkg
`default_nettype wire

// file: afe_reg8.sv
`timescale 1ns/10ps
`default_nettype none
`include "afe_ctrl_map.svh"
// one eight-bit control register; soft reset forces the power-on value
module afe_reg8 #(
    parameter logic [2:0] ADDR = 3'h0
) (
    input  wire logic                   clk,
    input  wire logic                   reset,
    input  wire logic                   soft_reset,
    input  wire afe_ctrl_pkg::reg_write_t wr,
    output logic [7:0]                  q
);
    import afe_ctrl_pkg::*;
    logic [7:0] next_q;

    always_comb begin
        next_q = q;
        if (soft_reset) begin
            next_q = `REG_RESET_VALUE;
        end else if (wr.valid && wr.addr == ADDR) begin
            next_q = wr.data;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            q <= `REG_RESET_VALUE;
        end else begin
            q <= next_q;
        end
    end
endmodule : afe_reg8
`default_nettype wire

// file: afe_control_register_bank.sv
`timescale 1ns/10ps
`default_nettype none
`include "afe_ctrl_map.svh"
//
// Behaviour
// - decimation rate comes from clock register bits 1:0
// - serial clock divider comes from clock register bits 3:2
// - master clock divider comes from clock register bits 6:4
// - echo enable set: every received control word is sent out
// - global power-up powers all six channels regardless of channel bits
// - power register bit 5 powers the reference up or down
// - reference powers up automatically whenever any channel is on
// - power register bit 6 enables the reference output pin
// - gain registers: odd channel low nibble, three gain bits, power on top
// - input mode: six selects, modulator reset bit 6, single-ended bit 7
// - mixed bit clear: mode bit picks program (0) or data (1)
// - mixed bit set: mixed mode, mode bit ignored
// - serial mode bit 3 selects serial loop-back
// - cascade count from serial mode bits 6:4, same on all devices
// - writing 1 to serial mode bit 7 starts a software reset
// - modulator reset holds selected channels only
// - single-ended applies to selected channels, else all differential
// - invert enable inverts selected channels; bit 6 is test mode
// - registers update on the falling serial clock edge
module afe_control_register_bank (
    input  wire logic                        clk,
    input  wire logic                        reset,
    input  wire logic                        sclk_fall,
    input  wire afe_ctrl_pkg::reg_write_t    wr,
    input  wire logic [15:0]                 word_in,
    input  wire logic                        word_in_valid,
    output logic [15:0]                      echo_word,
    output logic                             echo_valid,
    output afe_ctrl_pkg::port_config_t       port_cfg,
    output afe_ctrl_pkg::analog_config_t     analog_cfg,
    output logic                             soft_reset_active
);
    import afe_ctrl_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // register storage
    logic [7:0]  regs [8];
    logic        soft_reset;
    reg_write_t  wr_gated;

    // writes land only on the falling serial clock strobe
    assign wr_gated.valid = wr.valid && sclk_fall;
    assign wr_gated.addr  = wr.addr;
    assign wr_gated.data  = wr.data;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_reg
            // each register separate, so one write never touches another
            afe_reg8 #(
                .ADDR (3'(gi))
            ) u_reg (
                .clk        (clk),
                .reset      (reset),
                .soft_reset (soft_reset),
                .wr         (wr_gated),
                .q          (regs[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // software reset: one-cycle pulse, reset bit stored as 1 for one cycle until the pulse clears it
    logic next_soft_reset;

    always_comb begin
        next_soft_reset = wr_gated.valid && wr.addr == `ADDR_SERIAL_MODE
                          && wr.data[`SM_SOFT_RESET_BIT];
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            soft_reset <= 1'b0;
        end else begin
            soft_reset <= next_soft_reset;
        end
    end

    assign soft_reset_active = soft_reset;

    ////////////////////////////////////////////////////////////////////////////////
    // serial port configuration
    logic [7:0] sm;
    logic [7:0] cr;
    assign sm = regs[`ADDR_SERIAL_MODE];
    assign cr = regs[`ADDR_CLOCK_RATE];

    always_comb begin
        if (sm[`SM_MIXED_BIT]) begin
            port_cfg.op_mode = mode_mixed;
        end else if (sm[`SM_OPMODE_BIT]) begin
            port_cfg.op_mode = mode_data;
        end else begin
            port_cfg.op_mode = mode_program;
        end
        port_cfg.serial_loopback_enable = sm[`SM_LOOPBACK_BIT];
        port_cfg.cascade_count       = sm[`SM_CASCADE_LSB +: 3];
        port_cfg.decimation_rate     = cr[`CR_DECIM_LSB +: 2];
        port_cfg.serial_clock_div    = cr[`CR_SCLK_DIV_LSB +: 2];
        port_cfg.master_clock_div    = cr[`CR_MCLK_DIV_LSB +: 3];
        port_cfg.control_echo_enable = cr[`CR_ECHO_BIT];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // control echo: registered copy of each received word
    logic [15:0] next_echo_word;
    logic        next_echo_valid;

    always_comb begin
        next_echo_valid = word_in_valid && cr[`CR_ECHO_BIT];
        next_echo_word  = next_echo_valid ? word_in : echo_word;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            echo_word  <= 16'h0000;
            echo_valid <= 1'b0;
        end else begin
            echo_word  <= next_echo_word;
            echo_valid <= next_echo_valid;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // analog configuration
    logic [7:0] pr;
    logic [7:0] im;
    logic [7:0] iv;
    logic [5:0] ch_bits;
    assign pr = regs[`ADDR_POWER_REF];
    assign im = regs[`ADDR_INPUT_MODE];
    assign iv = regs[`ADDR_INVERT];

    always_comb begin
        for (int c = 0; c < 3; c++) begin
            ch_bits[2*c]   = regs[`ADDR_GAIN_CH12 + 3'(c)][`GP_LOW_POWER_BIT];
            ch_bits[2*c+1] = regs[`ADDR_GAIN_CH12 + 3'(c)][`GP_HIGH_POWER_BIT];
            analog_cfg.channel_gain[6*c +: 3] =
                regs[`ADDR_GAIN_CH12 + 3'(c)][`GP_LOW_GAIN_LSB +: 3];
            analog_cfg.channel_gain[6*c+3 +: 3] =
                regs[`ADDR_GAIN_CH12 + 3'(c)][`GP_HIGH_GAIN_LSB +: 3];
        end
        // global power-up overrides the per-channel bits
        analog_cfg.channel_power = pr[`PR_GLOBAL_BIT] ? 6'h3f : ch_bits;
        // reference follows its bit but is forced on by any live channel
        analog_cfg.reference_power_on = pr[`PR_REF_POWER_BIT]
                                        || (|analog_cfg.channel_power);
        analog_cfg.reference_output_pin = pr[`PR_REF_OUT_BIT];
        analog_cfg.modulator_reset = im[`IM_MOD_RESET_BIT]
                                     ? im[`SEL_LSB +: 6] : 6'h00;
        analog_cfg.single_ended = im[`IM_SINGLE_BIT]
                                  ? im[`SEL_LSB +: 6] : 6'h00;
        analog_cfg.invert = iv[`IV_ENABLE_BIT] ? iv[`SEL_LSB +: 6] : 6'h00;
        analog_cfg.test_mode_bit = iv[`IV_TEST_BIT];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    // flat copy and write strobes, only for the properties below
    logic [63:0] regs_flat;
    logic [7:0]  wr_taken;
    assign regs_flat = {regs[7], regs[6], regs[5], regs[4],
                        regs[3], regs[2], regs[1], regs[0]};

    always_comb begin
        wr_taken = 8'h00;
        // built from the raw inputs so a broken write gate cannot hide itself
        if (wr.valid && sclk_fall && !soft_reset) begin
            wr_taken[wr.addr] = 1'b1;
        end
    end

    // storage, timing and soft reset
    // write checks look one edge back, so a lost or early update shows up
    AST_SOFT_RESET_CLEARS: assert property (@(posedge clk) disable iff (reset)
        soft_reset |=> (regs_flat == 64'h0 && !soft_reset))
        else $error("soft reset did not restore defaults");
    AST_SOFT_RESET_CAUSE: assert property (@(posedge clk) disable iff (reset)
        (wr.valid && sclk_fall && wr.addr == 3'h0 && wr.data[7]) |=> soft_reset)
        else $error("reset bit write did not start soft reset");
    AST_SOFT_RESET_ONLY_WRITE: assert property (@(posedge clk) disable iff (reset)
        !(wr.valid && sclk_fall && wr.addr == 3'h0 && wr.data[7]) |=> !soft_reset)
        else $error("soft reset without a reset bit write");
    AST_WRITE_NEEDS_EDGE: assert property (@(posedge clk) disable iff (reset)
        (wr.valid && !sclk_fall && wr.addr == 3'h2 && wr.data != regs[2])
        |=> $stable(regs[2]))
        else $error("register changed without falling serial edge");
    AST_NO_EDGE_NO_CHANGE: assert property (@(posedge clk) disable iff (reset)
        (!(wr.valid && sclk_fall) && !soft_reset) |=> $stable(regs_flat))
        else $error("register changed with no write taken");
    AST_WRITE_LANDS: assert property (@(posedge clk) disable iff (reset)
        (wr.valid && sclk_fall && wr.addr == 3'h6 && !soft_reset) |=> regs[6] == $past(wr.data))
        else $error("write did not land");
    AST_INPUT_KEEPS_INVERT: assert property (@(posedge clk) disable iff (reset)
        wr_taken[6] |=> $stable(regs[7]))
        else $error("input mode write disturbed invert selects");
    AST_INVERT_KEEPS_INPUT: assert property (@(posedge clk) disable iff (reset)
        wr_taken[7] |=> $stable(regs[6]))
        else $error("invert write disturbed input mode selects");

    // serial port fields
    AST_DECIM_WRITE: assert property (@(posedge clk) disable iff (reset)
        wr_taken[1] |=> port_cfg.decimation_rate == $past(wr.data[1:0]))
        else $error("decimation rate field not taken");
    AST_SCLK_DIV_WRITE: assert property (@(posedge clk) disable iff (reset)
        wr_taken[1] |=> port_cfg.serial_clock_div == $past(wr.data[3:2]))
        else $error("serial clock divider field not taken");
    AST_MCLK_DIV_WRITE: assert property (@(posedge clk) disable iff (reset)
        wr_taken[1] |=> port_cfg.master_clock_div == $past(wr.data[6:4]))
        else $error("master clock divider field not taken");
    AST_ECHO_BIT_WRITE: assert property (@(posedge clk) disable iff (reset)
        wr_taken[1] |=> port_cfg.control_echo_enable == $past(wr.data[7]))
        else $error("echo enable bit not taken");
    AST_ECHO: assert property (@(posedge clk) disable iff (reset)
        (word_in_valid && cr[7]) |=> (echo_valid && echo_word == $past(word_in)))
        else $error("control word not echoed");
    AST_NO_ECHO: assert property (@(posedge clk) disable iff (reset)
        !cr[7] |=> !echo_valid)
        else $error("echo while disabled");
    AST_ECHO_HOLDS: assert property (@(posedge clk) disable iff (reset)
        !(word_in_valid && cr[7]) |=> $stable(echo_word))
        else $error("echo word changed without an echo");
    AST_MIXED_MODE: assert property (@(posedge clk) disable iff (reset)
        sm[1] |-> port_cfg.op_mode == mode_mixed)
        else $error("mixed bit ignored");
    AST_MODE_SELECT: assert property (@(posedge clk) disable iff (reset)
        (wr_taken[0] && !wr.data[1])
        |=> port_cfg.op_mode == ($past(wr.data[0]) ? mode_data : mode_program))
        else $error("program or data mode not selected");
    AST_LOOPBACK_WRITE: assert property (@(posedge clk) disable iff (reset)
        wr_taken[0] |=> port_cfg.serial_loopback_enable == $past(wr.data[3]))
        else $error("loop-back bit not taken");
    AST_CASCADE_WRITE: assert property (@(posedge clk) disable iff (reset)
        wr_taken[0] |=> port_cfg.cascade_count == $past(wr.data[6:4]))
        else $error("cascade count not taken");

    // power, reference, gain, input and invert fields
    AST_GLOBAL_POWER: assert property (@(posedge clk) disable iff (reset)
        pr[0] |-> analog_cfg.channel_power == 6'h3f)
        else $error("global power-up did not power all channels");
    AST_REF_AUTO: assert property (@(posedge clk) disable iff (reset)
        (|analog_cfg.channel_power) |-> analog_cfg.reference_power_on)
        else $error("reference off with a channel on");
    AST_REF_POWER_UP: assert property (@(posedge clk) disable iff (reset)
        (wr_taken[2] && wr.data[5]) |=> analog_cfg.reference_power_on)
        else $error("reference bit did not power the reference");
    AST_REF_POWER_DOWN: assert property (@(posedge clk) disable iff (reset)
        (!pr[5] && analog_cfg.channel_power == 6'h00) |-> !analog_cfg.reference_power_on)
        else $error("reference on with no cause");
    AST_REF_OUT_WRITE: assert property (@(posedge clk) disable iff (reset)
        wr_taken[2] |=> analog_cfg.reference_output_pin == $past(wr.data[6]))
        else $error("reference output bit not taken");
    AST_GAIN_CH12: assert property (@(posedge clk) disable iff (reset)
        wr_taken[3] |=> analog_cfg.channel_gain[5:0] == $past({wr.data[6:4], wr.data[2:0]}))
        else $error("gain of channels one and two not taken");
    AST_GAIN_CH34: assert property (@(posedge clk) disable iff (reset)
        wr_taken[4] |=> analog_cfg.channel_gain[11:6] == $past({wr.data[6:4], wr.data[2:0]}))
        else $error("gain of channels three and four not taken");
    AST_GAIN_CH56: assert property (@(posedge clk) disable iff (reset)
        wr_taken[5] |=> analog_cfg.channel_gain[17:12] == $past({wr.data[6:4], wr.data[2:0]}))
        else $error("gain of channels five and six not taken");
    AST_POWER_CH12: assert property (@(posedge clk) disable iff (reset)
        (wr_taken[3] && !pr[0])
        |=> analog_cfg.channel_power[1:0] == $past({wr.data[7], wr.data[3]}))
        else $error("power of channels one and two not taken");
    AST_POWER_CH34: assert property (@(posedge clk) disable iff (reset)
        (wr_taken[4] && !pr[0])
        |=> analog_cfg.channel_power[3:2] == $past({wr.data[7], wr.data[3]}))
        else $error("power of channels three and four not taken");
    AST_POWER_CH56: assert property (@(posedge clk) disable iff (reset)
        (wr_taken[5] && !pr[0])
        |=> analog_cfg.channel_power[5:4] == $past({wr.data[7], wr.data[3]}))
        else $error("power of channels five and six not taken");
    AST_MOD_RESET_WRITE: assert property (@(posedge clk) disable iff (reset)
        wr_taken[6] |=> analog_cfg.modulator_reset
                        == ($past(wr.data[6]) ? $past(wr.data[5:0]) : 6'h00))
        else $error("modulator reset select wrong");
    AST_SINGLE_SEL: assert property (@(posedge clk) disable iff (reset)
        wr_taken[6] |=> analog_cfg.single_ended
                        == ($past(wr.data[7]) ? $past(wr.data[5:0]) : 6'h00))
        else $error("single-ended select wrong");
    AST_INVERT_SEL: assert property (@(posedge clk) disable iff (reset)
        !iv[7] |-> analog_cfg.invert == 6'h00)
        else $error("invert active while disabled");
    AST_INVERT_WRITE: assert property (@(posedge clk) disable iff (reset)
        wr_taken[7] |=> analog_cfg.invert
                        == ($past(wr.data[7]) ? $past(wr.data[5:0]) : 6'h00))
        else $error("invert select wrong");
    AST_TEST_MODE_WRITE: assert property (@(posedge clk) disable iff (reset)
        wr_taken[7] |=> analog_cfg.test_mode_bit == $past(wr.data[6]))
        else $error("test mode bit not taken");

    COV_SOFT_RESET: cover property (@(posedge clk) soft_reset);
    COV_MIXED: cover property (@(posedge clk) port_cfg.op_mode == mode_mixed);
    COV_ECHO: cover property (@(posedge clk) echo_valid);
    COV_MOD_RESET: cover property (@(posedge clk) analog_cfg.modulator_reset != 6'h00);
    COV_LOOPBACK: cover property (@(posedge clk) port_cfg.serial_loopback_enable);
endmodule : afe_control_register_bank
`default_nettype wire

// file: host_write_model.sv
`timescale 1ns/10ps
`default_nettype none
// host side: decoded writes and raw control words, driven on falling clk edges
module host_write_model (
    input  wire logic                clk,
    output afe_ctrl_pkg::reg_write_t wr,
    output logic                     sclk_fall,
    output logic [15:0]              word_in,
    output logic                     word_in_valid
);
    import afe_ctrl_pkg::*;
    logic [7:0] mode_reg;
    initial begin
        wr = '0;
        sclk_fall = 1'b0;
        word_in = 16'h0000;
        word_in_valid = 1'b0;
        mode_reg = 8'h00;
    end
    task automatic write_reg(input logic [2:0] a, input logic [7:0] d, input logic sf,
                             output logic [7:0] sent);
        sent = d;
        if (a == 3'h0) sent[2] = 1'b0;
        if (a == 3'h2) sent = sent & 8'h61;
        if (a == 3'h7) sent[6] = 1'b0;
        if (a == 3'h1 && mode_reg[1:0] != 2'b00) sent[7] = 1'b0;
        @(negedge clk);
        wr <= '{valid: 1'b1, addr: a, data: sent};
        sclk_fall <= sf;
        // one device only, so the cascade count trivially agrees
        if (sf && a == 3'h0) mode_reg = sent[7] ? 8'h00 : sent;
        @(posedge clk);
    endtask : write_reg
    // released lines flip so stale values never look valid
    task automatic idle();
        @(negedge clk);
        wr <= '{valid: 1'b0, addr: ~wr.addr, data: ~wr.data};
        sclk_fall <= 1'b0;
        word_in <= ~word_in;
        word_in_valid <= 1'b0;
    endtask : idle
    task automatic send_word(input logic [15:0] w);
        @(negedge clk);
        word_in <= w;
        word_in_valid <= 1'b1;
        @(posedge clk);
    endtask : send_word
endmodule : host_write_model
`default_nettype wire

// file: testbench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHECK(g, e, m) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
    $display("MISMATCH t=%0t %s", $time, m); end end
module testbench;
    import afe_ctrl_pkg::*;
    logic           clk = 1'b0;
    logic           reset = 1'b1;
    reg_write_t     wr;
    logic           sclk_fall;
    logic [15:0]    word_in;
    logic           word_in_valid;
    logic [15:0]    echo_word;
    logic           echo_valid;
    port_config_t   port_cfg;
    analog_config_t analog_cfg;
    logic           soft_reset_active;
    logic [7:0]     sh [8];
    int             fail_count = 0;
    int             checks_done = 0;
    integer         seed = 32'h117b;
    logic [10:0]    corner [8] = '{11'h200, 11'h300, 11'h400, 11'h580, 11'h500, 11'h220,
                                   11'h6c5, 11'h79a};
    always #4 clk = ~clk;
    afe_control_register_bank afe_control_register_bank_i (.clk(clk), .reset(reset),
        .sclk_fall(sclk_fall), .wr(wr), .word_in(word_in), .word_in_valid(word_in_valid),
        .echo_word(echo_word), .echo_valid(echo_valid), .port_cfg(port_cfg),
        .analog_cfg(analog_cfg), .soft_reset_active(soft_reset_active));
    host_write_model host_write_model_i (.clk(clk), .wr(wr), .sclk_fall(sclk_fall),
        .word_in(word_in), .word_in_valid(word_in_valid));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic port_config_t exp_port();
        port_config_t p;
        p.op_mode = sh[0][1] ? mode_mixed : (sh[0][0] ? mode_data : mode_program);
        p.serial_loopback_enable = sh[0][3];
        p.cascade_count = sh[0][6:4];
        p.decimation_rate = sh[1][1:0];
        p.serial_clock_div = sh[1][3:2];
        p.master_clock_div = sh[1][6:4];
        p.control_echo_enable = sh[1][7];
        return p;
    endfunction : exp_port
    function automatic analog_config_t exp_analog();
        analog_config_t a;
        a.channel_power = sh[2][0] ? 6'h3f
                        : {sh[5][7], sh[5][3], sh[4][7], sh[4][3], sh[3][7], sh[3][3]};
        a.channel_gain = {sh[5][6:4], sh[5][2:0], sh[4][6:4], sh[4][2:0], sh[3][6:4],
                          sh[3][2:0]};
        a.reference_power_on = sh[2][5] | (|a.channel_power);
        a.reference_output_pin = sh[2][6];
        a.modulator_reset = sh[6][6] ? sh[6][5:0] : 6'h00;
        a.single_ended = sh[6][7] ? sh[6][5:0] : 6'h00;
        a.invert = sh[7][7] ? sh[7][5:0] : 6'h00;
        a.test_mode_bit = sh[7][6];
        return a;
    endfunction : exp_analog
    task automatic check_cfg(input string m);
        `CHECK(port_cfg, exp_port(), m)
        `CHECK(analog_cfg, exp_analog(), m)
    endtask : check_cfg
    // outputs settle on the taking edge itself; sampled just after it
    task automatic do_write(input logic [2:0] a, input logic [7:0] d, input logic sf);
        logic [7:0] m;
        host_write_model_i.write_reg(a, d, sf, m);
        if (sf) sh[a] = m;
        #1;
        check_cfg("config after write");
    endtask : do_write
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        fail_count++;
        print_verdict();
    end
    initial begin
        logic [7:0] d;
        logic [2:0] a;
        repeat (8) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        foreach (sh[i]) sh[i] = 8'h00;
        @(posedge clk);
        #1;
        check_cfg("reset values");
        $display("test reset done");
        for (int k = 0; k < 4; k++) begin
            do_write(3'h0, {1'b0, 3'(k * 3), k[0], 1'b0, k[1:0]}, 1'b1);
        end
        do_write(3'h0, 8'h00, 1'b1);
        $display("test modes done");
        foreach (corner[i]) do_write(corner[i][10:8], corner[i][7:0], 1'b1);
        do_write(3'h3, 8'h5a, 1'b0);
        $display("test corners done");
        do_write(3'h1, 8'ha5, 1'b1);
        host_write_model_i.idle();
        host_write_model_i.send_word(16'hc3e1);
        #1;
        `CHECK({echo_valid, echo_word}, 17'h1c3e1, "echo copy")
        host_write_model_i.idle();
        @(posedge clk);
        #1;
        `CHECK(echo_valid, 1'b0, "echo pulse length")
        do_write(3'h1, 8'h25, 1'b1);
        host_write_model_i.idle();
        host_write_model_i.send_word(16'h4a0f);
        #1;
        `CHECK(echo_valid, 1'b0, "echo while off")
        $display("test echo done");
        repeat (80) begin
            a = 3'($random(seed));
            d = 8'($random(seed));
            if (a == 3'h0) d[7] = 1'b0;
            do_write(a, d, 1'(($random(seed) & 3) != 0));
        end
        $display("test random done");
        do_write(3'h0, 8'hb1, 1'b1);
        `CHECK(soft_reset_active, 1'b1, "soft reset pulse")
        host_write_model_i.idle();
        foreach (sh[i]) sh[i] = 8'h00;
        @(posedge clk);
        #1;
        `CHECK(soft_reset_active, 1'b0, "soft reset self clear")
        check_cfg("after soft reset");
        do_write(3'h2, 8'h01, 1'b1);
        host_write_model_i.idle();
        $display("test soft reset done");
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
